// File: hdl/sasr_readout.sv
// conversion sequencer and serial readout of the successive-approximation converter
`timescale 1ns/1ps
`include "sasr_defs.svh"

module sasr_readout
  import sasr_pkg::*;
#(
  parameter int ACQ_MIN_CYC = `SASR_ACQ_MIN_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // serial interface
  input  wire sasr_pins_t pins,
  output logic            dout,
  output logic            dout_oe,
  // analog core
  input  wire logic       cmp_above,
  output sasr_sar_t       sar,
  // status
  output logic            auto_power_down,
  output logic            conv_busy,
  output logic            result_ready,
  output logic            acq_short
);

  // ============================================================
  // edge detection
  // both pins are sampled on ref_clk, so each serial clock level must stand
  // for two cycles or more; the top serial rate is bounded by that sampling
  // only falling edges matter, the rising outputs stay open
  logic sclk_fall;
  logic cs_fall;

  sasr_edge #(.IDLE(1'b0)) u_sclk_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sig     (pins.sclk),
    .rise    (),
    .fall    (sclk_fall)
  );

  sasr_edge #(.IDLE(1'b1)) u_cs_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sig     (pins.cs_n),
    .rise    (),
    .fall    (cs_fall)
  );

  // ============================================================
  // registers
  sasr_state_t                state_r;
  sasr_state_t                state_nxt;
  logic [`SASR_EDGE_W-1:0]    edge_cnt_r;
  logic [`SASR_EDGE_W-1:0]    edge_cnt_nxt;
  logic [`SASR_RES_W-1:0]     code_r;
  logic [`SASR_RES_W-1:0]     code_nxt;
  logic                       track_r;
  logic                       dout_r;
  logic                       dout_nxt;
  logic                       oe_r;
  logic [`SASR_ACQ_CNT_W-1:0] acq_cnt_r;
  logic                       acq_short_r;

  // ============================================================
  // state decode
  // one-hot, so each decode reduces to a single state flop
  wire        in_shutdown  = (state_r == SASR_SHUTDOWN);
  wire        in_acquire   = (state_r == SASR_ACQUIRE);
  wire        in_convert   = (state_r == SASR_CONVERT);
  wire        in_readout   = (state_r == SASR_READOUT);

  // ============================================================
  // decode of the falling edge that is about to complete
  wire        frame_active = ~pins.cs_n & ~in_shutdown;
  wire        step         = frame_active & sclk_fall;
  wire        cnt_sat      = (edge_cnt_r == `SASR_EDGE_SAT);
  // the count stops one past the last bit so trailing edges never wrap into data
  wire [`SASR_EDGE_W-1:0] edge_inc = edge_cnt_r + 5'h01;
  wire [`SASR_EDGE_W-1:0] edge_new = cnt_sat ? edge_cnt_r : edge_inc;
  wire        at_acq_end   = step & (edge_new == `SASR_EDGE_ACQ_END);
  wire        in_sar       = step & (edge_new > `SASR_EDGE_ACQ_END)
                                  & (edge_new <= `SASR_EDGE_SAR_LAST);
  wire        sar_done     = (edge_new == `SASR_EDGE_SAR_LAST);
  wire [3:0]  sar_bit      = 4'(`SASR_EDGE_SAR_LAST - edge_new);
  wire        in_data      = (edge_new > (`SASR_EDGE_OUT_LAST - 5'(`SASR_RES_W)))
                           & (edge_new <= `SASR_EDGE_OUT_LAST);
  wire [3:0]  out_bit      = 4'(`SASR_EDGE_OUT_LAST - edge_new);
  // leading zeros, result bits, then trailing zeros
  wire        data_bit     = in_data ? code_r[out_bit] : 1'b0;

  // successive approximation: keep or drop the trial bit, then try the next
  // cmp_above must already answer for code_r in the cycle that sees the fall
  logic [`SASR_RES_W-1:0] sar_code;
  always_comb begin
    sar_code = code_r;
    sar_code[sar_bit] = cmp_above;
    if (sar_bit != 4'h0) begin
      sar_code[sar_bit - 4'h1] = 1'b1;
    end
  end

  // ============================================================
  // next state
  always_comb begin
    state_nxt    = state_r;
    edge_cnt_nxt = edge_cnt_r;
    code_nxt     = code_r;
    dout_nxt     = dout_r;
    // select high outranks every edge, so an abort lands in the same cycle
    if (pins.cs_n) begin
      state_nxt    = SASR_SHUTDOWN;
      edge_cnt_nxt = '0;
      dout_nxt     = 1'b0;
    end else if (cs_fall) begin
      state_nxt    = SASR_ACQUIRE;
      edge_cnt_nxt = '0;
      code_nxt     = '0;
      dout_nxt     = 1'b0;
    end else if (step) begin
      edge_cnt_nxt = edge_new;
      dout_nxt     = data_bit;
      case (state_r)
        SASR_ACQUIRE: begin
          if (at_acq_end) begin
            state_nxt = SASR_CONVERT;
            code_nxt  = `SASR_DAC_MSB;
          end
        end
        SASR_CONVERT: begin
          if (in_sar) begin
            code_nxt = sar_code;
          end
          if (sar_done) begin
            state_nxt = SASR_READOUT;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // ============================================================
  // sequencer flops
  // one register stage: outputs move one ref_clk after the edge that causes them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= SASR_SHUTDOWN;
      edge_cnt_r <= '0;
      code_r     <= '0;
      dout_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      code_r     <= code_nxt;
      dout_r     <= dout_nxt;
    end
  end

  // output enable and track switch follow select
  // track closes for the whole acquisition and opens at hold or on abort
  wire        oe_nxt       = ~pins.cs_n;
  wire        track_nxt    = (state_nxt == SASR_ACQUIRE);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r    <= 1'b0;
      track_r <= 1'b0;
    end else begin
      oe_r    <= oe_nxt;
      track_r <= track_nxt;
    end
  end

  // acquisition length seen from select fall to hold, flagged when too short
  // the counter saturates so a very long track time never wraps to look short
  wire        acq_cnt_sat   = (acq_cnt_r == '1);
  wire        acq_too_short = (32'(acq_cnt_r) < 32'(ACQ_MIN_CYC - 1));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_cnt_r   <= '0;
      acq_short_r <= 1'b0;
    end else if (cs_fall) begin
      acq_cnt_r   <= '0;
      acq_short_r <= 1'b0;
    end else if (in_acquire) begin
      if (at_acq_end) begin
        acq_short_r <= acq_too_short;
      end else if (!acq_cnt_sat) begin
        acq_cnt_r <= acq_cnt_r + 8'h01;
      end
    end
  end

  // ============================================================
  // outputs
  assign dout            = dout_r;
  assign dout_oe         = oe_r;
  assign sar.track       = track_r;
  assign sar.code        = code_r;
  assign auto_power_down = in_shutdown;
  assign conv_busy       = in_acquire | in_convert;
  assign result_ready    = in_readout;
  assign acq_short       = acq_short_r;

endmodule

// File: hdl/sasr_defs.svh
// timing and sequence constants of the serial readout block
`ifndef SASR_DEFS_SVH
`define SASR_DEFS_SVH

// ============================================================
// clock and timing
`define SASR_REF_CLK_KHZ   20000
`define SASR_ACQ_MIN_NS    1100
`define SASR_SCLK_MAX_KHZ  4800
`define SASR_ACQ_MIN_CYC   ((`SASR_ACQ_MIN_NS * `SASR_REF_CLK_KHZ + 999999) / 1000000)

// ============================================================
// falling edge sequence of one frame
`define SASR_EDGE_W        5
`define SASR_EDGE_ACQ_END  5'h06
`define SASR_EDGE_SAR_LAST 5'h16
`define SASR_EDGE_OUT_LAST 5'h18
`define SASR_EDGE_SAT      5'h19
`define SASR_RES_W         16
`define SASR_ACQ_CNT_W     8
`define SASR_DAC_MSB       16'h8000

`endif

// File: hdl/sasr_pkg.sv
// types of the serial readout block
`include "sasr_defs.svh"

package sasr_pkg;

  // ============================================================
  // frame state, one-hot
  typedef enum logic [3:0] {
    SASR_SHUTDOWN = 4'b0001,
    SASR_ACQUIRE  = 4'b0010,
    SASR_CONVERT  = 4'b0100,
    SASR_READOUT  = 4'b1000
  } sasr_state_t;

  // ============================================================
  // serial pins seen by the device
  typedef struct packed {
    logic cs_n;
    logic sclk;
  } sasr_pins_t;

  // ============================================================
  // analog core control
  typedef struct packed {
    logic                     track;
    logic [`SASR_RES_W-1:0]   code;
  } sasr_sar_t;

endpackage

// File: hdl/sasr_edge.sv
// rising and falling edge detector for a synchronous input
`timescale 1ns/1ps

module sasr_edge
  import sasr_pkg::*;
#(
  parameter logic IDLE = 1'b0
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // level in
  input  wire logic sig,
  // edge pulses
  output logic      rise,
  output logic      fall
);

  logic prev_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= IDLE;
    end else begin
      prev_r <= sig;
    end
  end

  assign rise = sig & ~prev_r;
  assign fall = ~sig & prev_r;

endmodule

// File: test/sasr_readout_sva.sv
// assertions on the serial readout ports
`timescale 1ns/1ps
`include "sasr_defs.svh"
module sasr_chk
  import sasr_pkg::*;
(
  // clock, reset and pins
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire sasr_pins_t pins,
  // device outputs
  input wire logic       dout,
  input wire logic       dout_oe,
  input wire sasr_sar_t  sar,
  input wire logic       auto_power_down,
  input wire logic       conv_busy,
  input wire logic       result_ready
);
  // ====================
  // falling edges seen in the frame
  logic       sclk_r;
  logic [4:0] fc_r;
  wire        fall = sclk_r & ~pins.sclk & ~pins.cs_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
      fc_r   <= 5'h00;
    end else begin
      sclk_r <= pins.sclk;
      fc_r   <= pins.cs_n ? 5'h00 : fc_r + {4'h0, fall & (fc_r != 5'h1f)};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_awake;
    dout_oe && !dout && sar.track && conv_busy && !auto_power_down;
  endsequence
  oe_off_a: assert property (pins.cs_n |=> !dout_oe) else $error("output enabled while deselected");
  wake_up_a: assert property ($fell(pins.cs_n) |=> s_awake) else $error("no wake on select fall");
  deselect_sleep_a: assert property (pins.cs_n |=> auto_power_down && !conv_busy && !result_ready)
    else $error("not asleep while deselected");
  dout_edge_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> $past(fall))
    else $error("data moved without clock fall");
  lead_zero_a: assert property (dout_oe && fc_r <= 5'h08 |-> !dout) else $error("leading bit not zero");
  sixth_hold_a: assert property (fall && fc_r == 5'h05 |=> !sar.track && sar.code == `SASR_DAC_MSB)
    else $error("no hold at sixth fall");
  conv_done_a: assert property (fall && fc_r == 5'h15 |=> result_ready && !conv_busy)
    else $error("result not ready after last trial");
  tail_zero_a: assert property (fall && fc_r >= 5'h18 |=> !dout && $stable(sar.code))
    else $error("trailing bit not zero");
endmodule
bind sasr_readout sasr_chk u_chk (.ref_clk, .rst_n, .pins, .dout, .dout_oe, .sar, .auto_power_down,
  .conv_busy, .result_ready);

// File: test/sasr_master.sv
// serial master model: drives select and clock, captures data on rising clock
`timescale 1ns/1ps
module sasr_master
  import sasr_pkg::*;
(
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  // serial link
  output sasr_pins_t  pins,
  input  wire logic   dout,
  input  wire logic   dout_oe,
  output logic [31:0] rx
);
  // released line shows a changing pattern
  wire line = dout_oe ? dout : ~rx[0];
  initial begin
    pins = '{cs_n: 1'b1, sclk: 1'b0};
    rx   = 32'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // sel low keeps select high; pre cycles of acquisition lead; n falls
  task automatic frame(input logic sel, input int pre, input int n);
    pins.cs_n <= ~sel;
    rx <= 32'h0;
    tick(pre);
    repeat (n) begin
      pins.sclk <= 1'b1;
      tick(1);
      rx <= {rx[30:0], line};
      tick(1);
      pins.sclk <= 1'b0;
      tick(2);
    end
    tick(1);
    rx <= {rx[30:0], line};
    tick(1);
  endtask
  task automatic deselect;
    pins.cs_n <= 1'b1;
    tick(3);
  endtask
endmodule

// File: test/sasr_readout_test.sv
// self-checking bench of the serial readout block
`timescale 1ns/1ps
module sasr_readout_test;
  import sasr_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        cmp_above;
  logic [15:0] analog_in_pin;
  sasr_pins_t  pins;
  sasr_sar_t   sar;
  logic        dout, dout_oe, apd, busy, ready, short;
  logic [31:0] rx;
  int          n_mismatch;
  int          checks;
  sasr_readout #(.ACQ_MIN_CYC(40)) u_dut (.ref_clk, .rst_n, .pins, .dout, .dout_oe, .cmp_above, .sar,
    .auto_power_down(apd), .conv_busy(busy), .result_ready(ready), .acq_short(short));
  sasr_master u_mst (.ref_clk, .rst_n, .pins, .dout, .dout_oe, .rx);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // analog core: input at or above trial code
  always @(posedge ref_clk) cmp_above <= analog_in_pin >= sar.code;
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_convert(input logic [15:0] v, input int pre, input logic sh);
    analog_in_pin <= v;
    u_mst.frame(1'b1, pre, 24);
    cmp("stream", {16'h0, v}, rx);
    cmp("ready", 32'h1, {31'h0, ready});
    cmp("short", {31'h0, sh}, {31'h0, short});
    u_mst.deselect();
    cmp("asleep", 32'h1, {31'h0, apd});
    cmp("enable", 32'h0, {31'h0, dout_oe});
    $display("convert %h done", v);
  endtask
  task automatic t_tail(input logic [15:0] v);
    analog_in_pin <= v;
    u_mst.frame(1'b1, 2, 28);
    cmp("tail stream", {12'h0, v, 4'h0}, rx);
    u_mst.deselect();
    $display("tail done");
  endtask
  task automatic t_abort(input logic [15:0] v);
    analog_in_pin <= v;
    u_mst.frame(1'b1, 2, 12);
    cmp("busy mid", 32'h1, {31'h0, busy});
    u_mst.deselect();
    cmp("aborted", 32'h4, {29'h0, apd, busy, ready});
    $display("abort done");
  endtask
  task automatic t_idle;
    u_mst.frame(1'b0, 2, 8);
    cmp("idle", 32'h4, {29'h0, apd, dout_oe, busy});
    $display("idle done");
  endtask
  initial begin
    rst_n      = 1'b0;
    analog_in_pin = 16'h0;
    n_mismatch = 0;
    checks     = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_idle();
    t_convert(16'h0000, 2, 1'b1);
    t_convert(16'hffff, 30, 1'b0);
    t_convert(16'ha5c3, 2, 1'b1);
    t_tail(16'h5a3c);
    t_abort(16'h1234);
    t_convert(16'h8001, 2, 1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
